/* hdl/frtc_pkg.sv */
package frtc_pkg;
  // Opcode low five bits
  localparam logic [4:0] OPC_READ_ID = 5'h0A;
  localparam logic [4:0] OPC_READ_TRACK = 5'h02;
  localparam logic [4:0] OPC_READ_DELETED = 5'h0C;
  localparam logic [3:0] LEN_READ_ID = 4'h2;
  localparam logic [3:0] LEN_READ_LONG = 4'h9;
  // Opcode and drive/head byte fields
  localparam int MULTI_SIDE_BIT = 7;
  localparam int ENCODING_SELECT_BIT = 6;
  localparam int SKIP_CONTROL_BIT = 5;
  localparam int IMPLIED_SEEK_BIT = 7;
  localparam int HEAD_SELECT_BIT = 2;
  localparam int DRIVE_SELECT_HIGH = 1;
  localparam int DRIVE_SELECT_LOW = 0;
  // Command byte indices
  localparam logic [3:0] CB_DRIVE = 4'h1;
  localparam logic [3:0] CB_TRACK = 4'h2;
  localparam logic [3:0] CB_HEAD = 4'h3;
  localparam logic [3:0] CB_SECTOR = 4'h4;
  localparam logic [3:0] CB_SIZE = 4'h5;
  localparam logic [3:0] CB_EOT = 4'h6;
  // Status fields
  localparam logic [1:0] TERM_NORMAL = 2'h0;
  localparam logic [1:0] TERM_ABNORMAL = 2'h1;
  localparam int ST1_MISSING_AM = 0;
  localparam int ST1_MISSING_DATA = 2;
  localparam int ST1_CRC = 5;
  localparam int ST1_END_OF_TRACK = 7;
  localparam int ST2_DATA_CRC = 5;
  localparam int ST2_CONTROL_MARK = 6;
  localparam logic [2:0] RESULT_LAST = 3'h6;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] FIRST_TRACK_SECTOR = 8'h01;

  typedef enum logic [2:0] {
    FRTC_IDLE, FRTC_CMD, FRTC_DELAY, FRTC_INDEX, FRTC_SEARCH, FRTC_MARK, FRTC_DATA,
    FRTC_RESULT
  } frtc_state_t;
endpackage : frtc_pkg

/* hdl/frtc_sync_edge.sv */
`timescale 1ns/1ps
module frtc_sync_edge (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic async_i,
  output logic rise_o
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign rise_o = sync_reg & ~last_reg;
endmodule : frtc_sync_edge

/* hdl/frtc_cmd.sv */
`timescale 1ns/1ps
// What this block does
// - Deleted read: normal sector sets control mark; stop, or skip when skip set.
// - Read-id opcode has encoding bit 6; second byte holds head and drive.
// - After last read-id byte, wait the programmed delay before anything else.
// - Read-id moves no data; interrupt raised when execution ends.
// - Read-id never requests an implied seek.
// - Read-id enables separator and reports first header found.
// - Read-id abort or missing mark gives termination code 01 and result phase; header CRC error is not checked.
// - Host FIFO write during read-id search aborts it.
// - Two index pulses without address mark: error, missing-mark flag bit 0.
// - Result is seven bytes: three status, track, head, sector, size.
// - Read-track takes nine command bytes like normal read.
// - Read-track reads physical order, delivered in DMA or non-DMA mode.
// - Read-track waits for index pulse before searching headers.
// - Host write before that index pulse: result with code 01.
// - Read-track compares all header bytes but sector; sector counts from 1.
// - Header mismatch sets missing-data bit 2, sector still read.
// - Header CRC error sets second status bit 5, sector still read.
// - Data CRC error sets bit 5 of second and third status; continue.
// - Read-track stops after end-of-track sectors, never other head.
// - Transfer count end gives termination code 00.
// - Interrupt at end of execution; host reads all result bytes.
module frtc_cmd
  import frtc_pkg::*;
#(
  parameter int DELAY_W = 16
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic host_wr_i,
  input wire logic [7:0] host_byte_i,
  input wire logic host_res_rd_i,
  output logic [7:0] res_byte_o,
  output logic res_valid_o,
  output logic irq_o,
  output logic busy_o,
  input wire logic [DELAY_W-1:0] delay_cycles_i,
  input wire logic dma_mode_i,
  input wire logic transfer_count_end_i,
  output logic [7:0] out_data_o,
  output logic dma_req_o,
  output logic pio_req_o,
  input wire logic index_n_i,
  output logic sep_enable_o,
  output logic encoding_select_o,
  output logic head_select_o,
  output logic [1:0] drive_select_o,
  output logic seek_req_o,
  input wire logic sep_id_valid_i,
  input wire logic [7:0] sep_id_track_i,
  input wire logic [7:0] sep_id_head_i,
  input wire logic [7:0] sep_id_sector_i,
  input wire logic [7:0] sep_id_size_i,
  input wire logic sep_id_crc_err_i,
  input wire logic sep_mark_valid_i,
  input wire logic sep_deleted_i,
  input wire logic sep_data_valid_i,
  input wire logic [7:0] sep_data_i,
  input wire logic sep_data_end_i,
  input wire logic sep_data_crc_err_i
);
  frtc_state_t state_reg;
  logic [7:0] cmd_reg [0:8];
  logic [3:0] cmd_cnt_reg;
  logic [DELAY_W-1:0] delay_reg;
  logic idx_cnt_reg;
  logic [7:0] sec_reg;
  logic [7:0] nsec_reg;
  logic [7:0] st0_reg, st1_reg, st2_reg;
  logic [7:0] id_reg [0:3];
  logic read_on_reg;
  logic stop_after_reg;
  logic [2:0] res_idx_reg;
  logic irq_reg;
  logic out_valid_reg;
  logic [7:0] out_data_reg;
  logic index_pulse;
  logic is_rid, is_rtrk, is_rdel;
  logic [4:0] opc_new;
  logic [3:0] cmd_len;
  logic id_mismatch;
  logic last_sector;
  logic [7:0] drive_byte;

  frtc_sync_edge u_index (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .async_i(~index_n_i),
    .rise_o(index_pulse)
  );

  assign opc_new = host_byte_i[4:0];
  assign is_rid = cmd_reg[0][4:0] == OPC_READ_ID;
  assign is_rtrk = cmd_reg[0][4:0] == OPC_READ_TRACK;
  assign is_rdel = cmd_reg[0][4:0] == OPC_READ_DELETED;
  assign cmd_len = is_rid ? LEN_READ_ID : LEN_READ_LONG;
  // Sector number left out of the read-track comparison
  assign id_mismatch = (sep_id_track_i != cmd_reg[CB_TRACK]) ||
    (sep_id_head_i != cmd_reg[CB_HEAD]) || (sep_id_size_i != cmd_reg[CB_SIZE]);
  assign last_sector = is_rtrk ? (nsec_reg + 8'h01 >= cmd_reg[CB_EOT]) :
    (sec_reg >= cmd_reg[CB_EOT]);
  // Read id ends on its drive byte; the long reads end on a later byte
  assign drive_byte = is_rid ? host_byte_i : cmd_reg[CB_DRIVE];

  // Command byte capture; unknown opcodes are stored in idle, but the state stays idle
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      for (int i = 0; i < 9; i++) begin
        cmd_reg[i] <= 8'h00;
      end
      cmd_cnt_reg <= 4'h0;
    end else if (host_wr_i && state_reg == FRTC_IDLE) begin
      cmd_reg[0] <= host_byte_i;
      cmd_cnt_reg <= 4'h1;
    end else if (host_wr_i && state_reg == FRTC_CMD) begin
      cmd_reg[cmd_cnt_reg] <= host_byte_i;
      cmd_cnt_reg <= cmd_cnt_reg + 4'h1;
    end
  end

  // Command execution and status
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg <= FRTC_IDLE;
      delay_reg <= '0;
      idx_cnt_reg <= 1'b0;
      sec_reg <= 8'h00;
      nsec_reg <= 8'h00;
      st0_reg <= STATUS_RESET;
      st1_reg <= STATUS_RESET;
      st2_reg <= STATUS_RESET;
      for (int i = 0; i < 4; i++) begin
        id_reg[i] <= 8'h00;
      end
      read_on_reg <= 1'b0;
      stop_after_reg <= 1'b0;
      res_idx_reg <= 3'h0;
      irq_reg <= 1'b0;
      seek_req_o <= 1'b0;
    end else begin
      seek_req_o <= 1'b0;
      case (state_reg)
        FRTC_IDLE: begin
          if (host_wr_i && (opc_new == OPC_READ_ID || opc_new == OPC_READ_TRACK ||
              opc_new == OPC_READ_DELETED)) begin
            state_reg <= FRTC_CMD;
          end
        end
        FRTC_CMD: begin
          if (host_wr_i && cmd_cnt_reg + 4'h1 == cmd_len) begin
            state_reg <= FRTC_DELAY;
            delay_reg <= delay_cycles_i;
            st1_reg <= STATUS_RESET;
            st2_reg <= STATUS_RESET;
            st0_reg <= {5'h00, drive_byte[HEAD_SELECT_BIT],
              drive_byte[DRIVE_SELECT_HIGH:DRIVE_SELECT_LOW]};
            read_on_reg <= 1'b0;
            stop_after_reg <= 1'b0;
          end
        end
        FRTC_DELAY: begin
          if (delay_reg != '0) begin
            delay_reg <= delay_reg - 1'b1;
          end else begin
            idx_cnt_reg <= 1'b0;
            nsec_reg <= 8'h00;
            sec_reg <= is_rtrk ? FIRST_TRACK_SECTOR : cmd_reg[CB_SECTOR];
            // Only the long reads may ask for an implied seek
            seek_req_o <= !is_rid && cmd_reg[CB_DRIVE][IMPLIED_SEEK_BIT];
            state_reg <= is_rtrk ? FRTC_INDEX : FRTC_SEARCH;
          end
        end
        FRTC_INDEX: begin
          if (host_wr_i) begin
            st0_reg[7:6] <= TERM_ABNORMAL;
            state_reg <= FRTC_RESULT;
            irq_reg <= 1'b1;
          end else if (index_pulse) begin
            state_reg <= FRTC_SEARCH;
          end
        end
        FRTC_SEARCH: begin
          if (is_rid && host_wr_i) begin
            st0_reg[7:6] <= TERM_ABNORMAL;
            state_reg <= FRTC_RESULT;
            irq_reg <= 1'b1;
          end else if (sep_id_valid_i && (is_rid || is_rtrk || (!sep_id_crc_err_i &&
              !id_mismatch && sep_id_sector_i == sec_reg))) begin
            id_reg[0] <= sep_id_track_i;
            id_reg[1] <= sep_id_head_i;
            id_reg[2] <= is_rtrk ? sec_reg : sep_id_sector_i;
            id_reg[3] <= sep_id_size_i;
            if (is_rid) begin
              st0_reg[7:6] <= TERM_NORMAL;
              state_reg <= FRTC_RESULT;
              irq_reg <= 1'b1;
            end else begin
              if (is_rtrk && id_mismatch) begin
                st1_reg[ST1_MISSING_DATA] <= 1'b1;
              end
              if (is_rtrk && sep_id_crc_err_i) begin
                st1_reg[ST1_CRC] <= 1'b1;
              end
              state_reg <= FRTC_MARK;
            end
          end else if (index_pulse && !is_rtrk) begin
            if (idx_cnt_reg) begin
              st1_reg[ST1_MISSING_AM] <= 1'b1;
              st0_reg[7:6] <= TERM_ABNORMAL;
              state_reg <= FRTC_RESULT;
              irq_reg <= 1'b1;
            end else begin
              idx_cnt_reg <= 1'b1;
            end
          end
        end
        FRTC_MARK: begin
          if (sep_mark_valid_i) begin
            if (is_rdel && !sep_deleted_i) begin
              st2_reg[ST2_CONTROL_MARK] <= 1'b1;
            end
            if (is_rdel && !sep_deleted_i && cmd_reg[0][SKIP_CONTROL_BIT]) begin
              // Skipped sector: advance without moving data
              if (last_sector) begin
                st1_reg[ST1_END_OF_TRACK] <= 1'b1;
                st0_reg[7:6] <= TERM_ABNORMAL;
                state_reg <= FRTC_RESULT;
                irq_reg <= 1'b1;
              end else begin
                sec_reg <= sec_reg + 8'h01;
                idx_cnt_reg <= 1'b0;
                state_reg <= FRTC_SEARCH;
              end
            end else begin
              read_on_reg <= 1'b1;
              stop_after_reg <= is_rdel && !sep_deleted_i;
              state_reg <= FRTC_DATA;
            end
          end
        end
        FRTC_DATA: begin
          if (transfer_count_end_i) begin
            st0_reg[7:6] <= TERM_NORMAL;
            read_on_reg <= 1'b0;
            state_reg <= FRTC_RESULT;
            irq_reg <= 1'b1;
          end else if (sep_data_end_i) begin
            read_on_reg <= 1'b0;
            nsec_reg <= nsec_reg + 8'h01;
            if (sep_data_crc_err_i) begin
              st1_reg[ST1_CRC] <= 1'b1;
              st2_reg[ST2_DATA_CRC] <= 1'b1;
            end
            if (stop_after_reg) begin
              st0_reg[7:6] <= TERM_NORMAL;
              state_reg <= FRTC_RESULT;
              irq_reg <= 1'b1;
            end else if (is_rdel && sep_data_crc_err_i) begin
              // Deleted read keeps normal-read behaviour on data CRC
              st0_reg[7:6] <= TERM_ABNORMAL;
              state_reg <= FRTC_RESULT;
              irq_reg <= 1'b1;
            end else if (last_sector) begin
              st1_reg[ST1_END_OF_TRACK] <= 1'b1;
              st0_reg[7:6] <= TERM_ABNORMAL;
              state_reg <= FRTC_RESULT;
              irq_reg <= 1'b1;
            end else begin
              sec_reg <= sec_reg + 8'h01;
              idx_cnt_reg <= 1'b0;
              state_reg <= FRTC_SEARCH;
            end
          end
        end
        FRTC_RESULT: begin
          if (host_res_rd_i) begin
            irq_reg <= 1'b0;
            if (res_idx_reg == RESULT_LAST) begin
              res_idx_reg <= 3'h0;
              state_reg <= FRTC_IDLE;
            end else begin
              res_idx_reg <= res_idx_reg + 3'h1;
            end
          end
        end
        default: begin
          state_reg <= FRTC_IDLE;
        end
      endcase
    end
  end

  // Data path toward the host; a byte stands until the next arrives
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      out_data_reg <= 8'h00;
      out_valid_reg <= 1'b0;
    end else begin
      out_valid_reg <= state_reg == FRTC_DATA && read_on_reg && sep_data_valid_i;
      if (state_reg == FRTC_DATA && read_on_reg && sep_data_valid_i) begin
        out_data_reg <= sep_data_i;
      end
    end
  end

  // Same seven-byte layout for all three commands
  always_comb begin
    case (res_idx_reg)
      3'h0: res_byte_o = st0_reg;
      3'h1: res_byte_o = st1_reg;
      3'h2: res_byte_o = st2_reg;
      3'h3: res_byte_o = id_reg[0];
      3'h4: res_byte_o = id_reg[1];
      3'h5: res_byte_o = id_reg[2];
      3'h6: res_byte_o = id_reg[3];
      default: res_byte_o = 8'h00;
    endcase
  end

  assign res_valid_o = state_reg == FRTC_RESULT;
  assign irq_o = irq_reg;
  assign busy_o = state_reg != FRTC_IDLE;
  assign out_data_o = out_data_reg;
  assign dma_req_o = out_valid_reg && dma_mode_i;
  assign pio_req_o = out_valid_reg && !dma_mode_i;
  assign sep_enable_o = state_reg == FRTC_SEARCH || state_reg == FRTC_MARK ||
    state_reg == FRTC_DATA;
  assign encoding_select_o = cmd_reg[0][ENCODING_SELECT_BIT];
  assign head_select_o = cmd_reg[CB_DRIVE][HEAD_SELECT_BIT];
  assign drive_select_o = cmd_reg[CB_DRIVE][DRIVE_SELECT_HIGH:DRIVE_SELECT_LOW];

  a_irq_on_result: assert property (@(posedge mclk_i) disable iff (reset_i)
    $rose(state_reg == FRTC_RESULT) |-> irq_o)
    else $error("result entered without interrupt");
  a_delay_holds: assert property (@(posedge mclk_i) disable iff (reset_i)
    (state_reg == FRTC_DELAY && delay_reg != '0) |=> state_reg == FRTC_DELAY)
    else $error("delay cut short");
  a_rid_abort: assert property (@(posedge mclk_i) disable iff (reset_i)
    (state_reg == FRTC_SEARCH && is_rid && host_wr_i) |=>
    (state_reg == FRTC_RESULT && st0_reg[7:6] == TERM_ABNORMAL))
    else $error("read id not aborted by host write");
  a_missing_am: assert property (@(posedge mclk_i) disable iff (reset_i)
    (state_reg == FRTC_SEARCH && is_rid && !host_wr_i && !sep_id_valid_i && idx_cnt_reg &&
    index_pulse) |=> (st1_reg[ST1_MISSING_AM] && state_reg == FRTC_RESULT))
    else $error("second index without missing mark");
  a_trk_index_abort: assert property (@(posedge mclk_i) disable iff (reset_i)
    (state_reg == FRTC_INDEX && host_wr_i) |=> st0_reg[7:6] == TERM_ABNORMAL)
    else $error("read track write before index not abnormal");
  a_tc_normal: assert property (@(posedge mclk_i) disable iff (reset_i)
    (state_reg == FRTC_DATA && transfer_count_end_i) |=>
    (state_reg == FRTC_RESULT && st0_reg[7:6] == TERM_NORMAL))
    else $error("terminal count not normal end");
  a_rid_no_seek: assert property (@(posedge mclk_i) disable iff (reset_i)
    (is_rid && state_reg != FRTC_IDLE && state_reg != FRTC_CMD) |-> !seek_req_o)
    else $error("read id requested a seek");
  a_rid_no_data: assert property (@(posedge mclk_i) disable iff (reset_i)
    (is_rid && busy_o) |-> !(dma_req_o || pio_req_o))
    else $error("read id moved data");
  a_trk_crc_go_on: assert property (@(posedge mclk_i) disable iff (reset_i)
    (state_reg == FRTC_DATA && is_rtrk && sep_data_end_i && sep_data_crc_err_i &&
    !transfer_count_end_i && !last_sector) |=> (state_reg == FRTC_SEARCH && st2_reg[ST2_DATA_CRC]))
    else $error("read track stopped on data crc");
  c_rid_done: cover property (@(posedge mclk_i) disable iff (reset_i)
    state_reg == FRTC_SEARCH && is_rid && sep_id_valid_i);
  c_trk_eot: cover property (@(posedge mclk_i) disable iff (reset_i)
    state_reg == FRTC_DATA && is_rtrk && sep_data_end_i && last_sector);
  c_del_skip: cover property (@(posedge mclk_i) disable iff (reset_i)
    state_reg == FRTC_MARK && is_rdel && sep_mark_valid_i && !sep_deleted_i &&
    cmd_reg[0][SKIP_CONTROL_BIT]);
endmodule : frtc_cmd

/* tb/frtc_disk_model.sv */
`timescale 1ns/1ps
module frtc_disk_model (
  input wire logic mclk_i,
  output logic index_n_o,
  output logic id_valid_o,
  output logic [31:0] id_hdr_o,
  output logic id_crc_err_o,
  output logic mark_valid_o,
  output logic deleted_o,
  output logic data_valid_o,
  output logic [7:0] data_o,
  output logic data_end_o,
  output logic data_crc_err_o
);
  initial begin
    index_n_o = 1'b1;
    {id_valid_o, mark_valid_o, data_valid_o, data_end_o} = 4'h0;
    {id_hdr_o, id_crc_err_o, deleted_o, data_o, data_crc_err_o} = 43'h0;
  end
  // Index line has a pull-up, so it idles high between pulses
  task automatic index_pulse();
    @(negedge mclk_i);
    index_n_o = 1'b0;
    repeat (4) @(negedge mclk_i);
    index_n_o = 1'b1;
  endtask : index_pulse
  // Fields invert after each strobe so a stale value never passes as fresh
  task automatic id_field(input logic [31:0] hdr, input logic crc);
    @(negedge mclk_i);
    id_hdr_o = hdr;
    id_crc_err_o = crc;
    id_valid_o = 1'b1;
    @(negedge mclk_i);
    id_valid_o = 1'b0;
    id_hdr_o = ~hdr;
    id_crc_err_o = ~crc;
  endtask : id_field
  task automatic data_field(input logic del, input int n, input logic crc, input logic fin);
    repeat (2) @(negedge mclk_i);
    deleted_o = del;
    mark_valid_o = 1'b1;
    @(negedge mclk_i);
    mark_valid_o = 1'b0;
    deleted_o = ~del;
    for (int i = 0; i < n; i++) begin
      @(negedge mclk_i);
      data_o = 8'hA0 + 8'(i);
      data_valid_o = 1'b1;
      @(negedge mclk_i);
      data_valid_o = 1'b0;
      data_o = ~data_o;
    end
    if (fin) begin
      @(negedge mclk_i);
      data_crc_err_o = crc;
      data_end_o = 1'b1;
      @(negedge mclk_i);
      data_end_o = 1'b0;
      data_crc_err_o = ~crc;
    end
    repeat (4) @(negedge mclk_i);
  endtask : data_field
endmodule : frtc_disk_model

/* tb/frtc_cmd_bench.sv */
`timescale 1ns/1ps
module frtc_cmd_bench;
  import frtc_pkg::*;
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  logic host_wr_i = 1'b0;
  logic [7:0] host_byte_i = 8'h00;
  logic host_res_rd_i = 1'b0;
  logic [15:0] delay_cycles_i = 16'h0003;
  logic dma_mode_i = 1'b1;
  logic transfer_count_end_i = 1'b0;
  logic index_n, id_valid, id_crc, mark_valid, deleted, data_valid, data_end, data_crc;
  logic [31:0] hdr;
  logic [7:0] sep_data, res_byte_o, out_data_o;
  logic res_valid_o, irq_o, busy_o, dma_req_o, pio_req_o, sep_enable_o;
  logic encoding_select_o, head_select_o, seek_req_o;
  logic [1:0] drive_select_o;
  int n_fail = 0;
  int total_checks = 0;
  int n_dma = 0;
  int n_pio = 0;
  int n_seek = 0;
  logic [7:0] got_q[$];
  always #5 mclk_i = ~mclk_i;
  frtc_cmd #(.DELAY_W(16)) frtc_cmd_inst (.mclk_i(mclk_i), .reset_i(reset_i),
    .host_wr_i(host_wr_i), .host_byte_i(host_byte_i), .host_res_rd_i(host_res_rd_i),
    .res_byte_o(res_byte_o), .res_valid_o(res_valid_o), .irq_o(irq_o), .busy_o(busy_o),
    .delay_cycles_i(delay_cycles_i), .dma_mode_i(dma_mode_i),
    .transfer_count_end_i(transfer_count_end_i), .out_data_o(out_data_o),
    .dma_req_o(dma_req_o), .pio_req_o(pio_req_o), .index_n_i(index_n),
    .sep_enable_o(sep_enable_o), .encoding_select_o(encoding_select_o),
    .head_select_o(head_select_o), .drive_select_o(drive_select_o), .seek_req_o(seek_req_o),
    .sep_id_valid_i(id_valid), .sep_id_track_i(hdr[31:24]), .sep_id_head_i(hdr[23:16]),
    .sep_id_sector_i(hdr[15:8]), .sep_id_size_i(hdr[7:0]), .sep_id_crc_err_i(id_crc),
    .sep_mark_valid_i(mark_valid), .sep_deleted_i(deleted), .sep_data_valid_i(data_valid),
    .sep_data_i(sep_data), .sep_data_end_i(data_end), .sep_data_crc_err_i(data_crc));
  frtc_disk_model frtc_disk_model_inst (.mclk_i(mclk_i), .index_n_o(index_n),
    .id_valid_o(id_valid), .id_hdr_o(hdr), .id_crc_err_o(id_crc), .mark_valid_o(mark_valid),
    .deleted_o(deleted), .data_valid_o(data_valid), .data_o(sep_data),
    .data_end_o(data_end), .data_crc_err_o(data_crc));
  always @(negedge mclk_i) begin
    if (dma_req_o === 1'b1) n_dma++;
    if (pio_req_o === 1'b1) n_pio++;
    if (seek_req_o === 1'b1) n_seek++;
    if ((dma_req_o | pio_req_o) === 1'b1) got_q.push_back(out_data_o);
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] b);
    @(negedge mclk_i);
    host_wr_i = 1'b1;
    host_byte_i = b;
    @(negedge mclk_i);
    host_wr_i = 1'b0;
  endtask : wr
  task automatic cmd(input logic [71:0] b, input int n);
    for (int i = 0; i < n; i++) wr(b[71-8*i -: 8]);
  endtask : cmd
  task automatic wait_on(input int which);
    int k;
    k = 0;
    while (((which == 0) ? sep_enable_o : res_valid_o) !== 1'b1 && k < 3000) begin
      @(negedge mclk_i);
      k++;
    end
    chk("wait", 8'h01, (k < 3000) ? 8'h01 : 8'h00);
  endtask : wait_on
  // Host drains all seven bytes, comparing the first n
  task automatic results(input logic [55:0] exp, input int n);
    wait_on(1);
    chk("irq", 8'h01, {7'h0, irq_o});
    for (int i = 0; i < 7; i++) begin
      if (i < n) chk("result", exp[55-8*i -: 8], res_byte_o);
      host_res_rd_i = 1'b1;
      @(negedge mclk_i);
      host_res_rd_i = 1'b0;
      @(negedge mclk_i);
    end
    chk("busy", 8'h00, {7'h0, busy_o});
  endtask : results
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  initial begin
    #200000;
    n_fail++;
    end_sim();
  end
  initial begin
    repeat (2) @(negedge mclk_i);
    reset_i = 1'b0;
    cmd({8'h4A, 8'h85, 56'h0}, 2);
    repeat (3) @(negedge mclk_i);
    chk("early search", 8'h00, {7'h0, sep_enable_o});
    chk("selects", 8'h0D, {4'h0, encoding_select_o, head_select_o, drive_select_o});
    wait_on(0);
    frtc_disk_model_inst.id_field(32'h12010302, 1'b0);
    results({8'h05, 8'h00, 8'h00, 32'h12010302}, 7);
    chk("seek", 8'h00, 8'(n_seek));
    chk("transfers", 8'h00, 8'(n_dma + n_pio));
    $display("test read_id done");
    cmd({8'h0A, 8'h02, 56'h0}, 2);
    wait_on(0);
    frtc_disk_model_inst.index_pulse();
    repeat (10) @(negedge mclk_i);
    chk("one index", 8'h00, {7'h0, res_valid_o});
    frtc_disk_model_inst.index_pulse();
    results({8'h42, 8'h01, 8'h00, 32'h0}, 3);
    cmd({8'h0A, 8'h00, 56'h0}, 2);
    wait_on(0);
    wr(8'h00);
    results({8'h40, 8'h00, 8'h00, 32'h0}, 3);
    $display("test read_id errors done");
    got_q.delete();
    cmd({8'h42, 8'h00, 8'h05, 8'h00, 8'h09, 8'h01, 8'h02, 8'h1B, 8'hFF}, 9);
    repeat (10) @(negedge mclk_i);
    chk("before index", 8'h00, {7'h0, sep_enable_o});
    frtc_disk_model_inst.index_pulse();
    wait_on(0);
    frtc_disk_model_inst.id_field(32'h05000701, 1'b0);
    frtc_disk_model_inst.data_field(1'b0, 2, 1'b1, 1'b1);
    frtc_disk_model_inst.id_field(32'h06000901, 1'b1);
    frtc_disk_model_inst.data_field(1'b0, 2, 1'b0, 1'b1);
    results({8'h40, 8'hA4, 8'h20, 32'h06000201}, 7);
    chk("head", 8'h00, {7'h0, head_select_o});
    chk("dma count", 8'h04, 8'(n_dma));
    chk("pio count", 8'h00, 8'(n_pio));
    for (int i = 0; i < 4; i++) chk("track data", 8'hA0 + 8'(i % 2), got_q[i]);
    cmd({8'h02, 8'h01, 8'h05, 8'h00, 8'h01, 8'h01, 8'h02, 8'h1B, 8'hFF}, 9);
    repeat (8) @(negedge mclk_i);
    wr(8'h00);
    results({8'h41, 48'h0}, 1);
    $display("test read_track done");
    dma_mode_i = 1'b0;
    got_q.delete();
    cmd({8'h4C, 8'h80, 8'h03, 8'h00, 8'h01, 8'h02, 8'h03, 8'h1B, 8'hFF}, 9);
    wait_on(0);
    frtc_disk_model_inst.id_field(32'h03000102, 1'b0);
    frtc_disk_model_inst.data_field(1'b0, 1, 1'b0, 1'b1);
    results({8'h00, 8'h00, 8'h40, 32'h03000102}, 7);
    chk("pio normal", 8'h01, 8'(n_pio));
    chk("seek long", 8'h01, 8'(n_seek));
    cmd({8'h6C, 8'h00, 8'h03, 8'h00, 8'h01, 8'h02, 8'h03, 8'h1B, 8'hFF}, 9);
    wait_on(0);
    frtc_disk_model_inst.id_field(32'h03000102, 1'b0);
    frtc_disk_model_inst.data_field(1'b0, 1, 1'b0, 1'b1);
    frtc_disk_model_inst.id_field(32'h03000202, 1'b0);
    frtc_disk_model_inst.data_field(1'b1, 1, 1'b0, 1'b0);
    transfer_count_end_i = 1'b1;
    @(negedge mclk_i);
    transfer_count_end_i = 1'b0;
    results({8'h00, 8'h00, 8'h40, 32'h03000202}, 7);
    chk("pio skip", 8'h02, 8'(n_pio));
    chk("skip data", 8'hA0, got_q[got_q.size()-1]);
    $display("test read_deleted done");
    end_sim();
  end
endmodule : frtc_cmd_bench
